// ### core/lcdd_top.sv
// segment lcd controller: registers, display memory, common sequencer
//
// How it works
// - drives 32 segment lines in static, half, third or quarter duty
// - sixteen byte display memory, reachable by byte or by word
// - unused segment pins are freed as port pins in groups of four
// - eleven frame rates selectable from subclock or system clock
// - software picks A or B drive waveform polarity scheme
// - display runs in every power mode except standby
// - module standby input shuts the whole driver down
// - each memory bit sets its segment state during its common phase
// - quarter duty uses four commons; even segment lower, odd upper nibble
// - third duty uses the same layout, ignoring the fourth common column
// - half duty uses only the first two commons' bits
// - static drive uses only the first common's bits
// - setting 000 is static on common one, others idle
// - setting 001 is static with all four commons identical
// - setting 010 is half duty on commons one and two only
// - setting 011 is half duty, common two copies one, four copies three
// - settings 100 and 101 both give third duty, common four idle
// - top two bits set select quarter duty on all four commons
// - select top bit clear: groups enabled upward from segments 1-4
// - select top bit set: eight all segments, higher values free groups
// - activate clear halts driver and supply; registers kept
// - display-data bit chooses blank segments or memory contents
`timescale 1ns/1ps
module lcdd_top (
    input wire logic CLK,
    input wire logic RST_B,
    input wire lcdd_pkg::lcdd_bus_req_t BUS_REQ,
    output logic [15:0] BUS_RDATA,
    input wire logic SUB_CLK,
    input wire logic STANDBY_MODE,
    input wire logic MODULE_STBY,
    output lcdd_pkg::lcdd_drive_t DRIVE,
    output logic [lcdd_pkg::NUM_SEG-1:0] SEG_OE,
    output logic [lcdd_pkg::NUM_SEG-1:0] PORT_SEL,
    output logic DRIVE_PWR_EN
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [7:0] pdc_r;
    logic [7:0] mc_r;
    logic [7:0] c2_r;
    logic [7:0] pdc_nxt;
    logic [7:0] mc_nxt;
    logic [7:0] c2_nxt;
    logic [7:0] ram_r [0:lcdd_pkg::RAM_BYTES-1];
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic sub_s1_r;
    logic sub_s2_r;
    logic sub_s3_r;
    logic [1:0] sub_cnt_r;
    logic [7:0] pre_cnt_r;
    lcdd_pkg::lcdd_seq_t state_r;
    lcdd_pkg::lcdd_seq_t state_nxt;
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    logic half_r;
    logic half_nxt;
    logic frame_r;
    logic frame_nxt;
    lcdd_pkg::lcdd_drive_t drive_r;
    lcdd_pkg::lcdd_drive_t drive_nxt;
    logic [lcdd_pkg::NUM_SEG-1:0] seg_oe_r;
    logic [lcdd_pkg::NUM_SEG-1:0] port_sel_r;
    logic pwr_r;

    // ------------------------------------------------------------------
    // bus helpers
    // ------------------------------------------------------------------
    function automatic logic byte_hit(input lcdd_pkg::lcdd_bus_req_t q,
                                      input logic [15:0] t);
        byte_hit = q.word ? (t[15:1] == q.addr[15:1]) : (t == q.addr);
    endfunction : byte_hit

    function automatic logic [7:0] byte_lane(input lcdd_pkg::lcdd_bus_req_t q,
                                             input logic [15:0] t);
        byte_lane = (q.word && !t[0]) ? q.wdata[15:8] : q.wdata[7:0];
    endfunction : byte_lane

    function automatic logic [7:0] reg_byte(input logic [15:0] t,
                                            input logic [7:0] ram_b,
                                            input logic [7:0] pdc,
                                            input logic [7:0] mc,
                                            input logic [7:0] c2);
        if (t[15:4] == lcdd_pkg::ADDR_RAM_BASE[15:4]) begin
            reg_byte = ram_b;
        end else if (t == lcdd_pkg::ADDR_PORT_DUTY) begin
            reg_byte = pdc & lcdd_pkg::PDC_WMASK;
        end else if (t == lcdd_pkg::ADDR_MAIN_CTRL) begin
            reg_byte = mc;
        end else if (t == lcdd_pkg::ADDR_CTRL2) begin
            reg_byte = c2 & lcdd_pkg::C2_WMASK;
        end else begin
            reg_byte = 8'h00;
        end
    endfunction : reg_byte

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    wire pdc_we = BUS_REQ.wr && byte_hit(BUS_REQ, lcdd_pkg::ADDR_PORT_DUTY);
    wire mc_we = BUS_REQ.wr && byte_hit(BUS_REQ, lcdd_pkg::ADDR_MAIN_CTRL);
    wire c2_we = BUS_REQ.wr && byte_hit(BUS_REQ, lcdd_pkg::ADDR_CTRL2);
    wire [7:0] pdc_wd = byte_lane(BUS_REQ, lcdd_pkg::ADDR_PORT_DUTY);
    wire [7:0] mc_wd = byte_lane(BUS_REQ, lcdd_pkg::ADDR_MAIN_CTRL);
    wire [7:0] c2_wd = byte_lane(BUS_REQ, lcdd_pkg::ADDR_CTRL2);

    assign pdc_nxt = pdc_we ? ((pdc_r & ~lcdd_pkg::PDC_WMASK) |
                               (pdc_wd & lcdd_pkg::PDC_WMASK)) : pdc_r;
    assign mc_nxt = mc_we ? ((mc_r & ~lcdd_pkg::MC_WMASK) |
                             (mc_wd & lcdd_pkg::MC_WMASK)) : mc_r;
    assign c2_nxt = c2_we ? ((c2_r & ~lcdd_pkg::C2_WMASK) |
                             (c2_wd & lcdd_pkg::C2_WMASK)) : c2_r;

    // contents survive a halt; only reset clears them
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pdc_r <= lcdd_pkg::PDC_RESET;
            mc_r <= lcdd_pkg::MC_RESET;
            c2_r <= lcdd_pkg::C2_RESET;
        end else begin
            pdc_r <= pdc_nxt;
            mc_r <= mc_nxt;
            c2_r <= c2_nxt;
        end
    end

    // ------------------------------------------------------------------
    // display memory
    // ------------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < lcdd_pkg::RAM_BYTES; k++) begin : g_ram
            wire [15:0] a_k = lcdd_pkg::ADDR_RAM_BASE + 16'(k);
            wire we_k = BUS_REQ.wr && byte_hit(BUS_REQ, a_k);
            wire [7:0] wd_k = byte_lane(BUS_REQ, a_k);
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    ram_r[k] <= 8'h00;
                end else if (we_k) begin
                    ram_r[k] <= wd_k;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    wire [15:0] rd_a0 = BUS_REQ.word ? {BUS_REQ.addr[15:1], 1'b0} :
                                       BUS_REQ.addr;
    wire [15:0] rd_a1 = {BUS_REQ.addr[15:1], 1'b1};
    wire [7:0] rd_b0 = reg_byte(rd_a0, ram_r[rd_a0[3:0]], pdc_r, mc_r, c2_r);
    wire [7:0] rd_b1 = reg_byte(rd_a1, ram_r[rd_a1[3:0]], pdc_r, mc_r, c2_r);

    assign rdata_nxt = !BUS_REQ.rd ? 16'h0000 :
                       BUS_REQ.word ? {rd_b0, rd_b1} : {8'h00, rd_b0};

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign BUS_RDATA = rdata_r;

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    wire lcdd_pkg::lcdd_duty_t duty_w =
        lcdd_pkg::lcdd_duty_t'(pdc_r[lcdd_pkg::PDC_DUTY_LSB +: 3]);
    wire [3:0] sgs_w = pdc_r[lcdd_pkg::PDC_SGS_LSB +: 4];
    wire psw_w = mc_r[lcdd_pkg::MC_PSW_BIT];
    wire act_w = mc_r[lcdd_pkg::MC_ACT_BIT];
    wire display_data_show_w = mc_r[lcdd_pkg::MC_DISPLAY_DATA_SHOW_BIT];
    wire [3:0] cks_w = mc_r[lcdd_pkg::MC_CKS_LSB +: 4];
    wire wave_b_w = c2_r[lcdd_pkg::C2_WAVE_BIT];

    wire running_w = act_w && !STANDBY_MODE && !MODULE_STBY;

    // ------------------------------------------------------------------
    // frame clock selection
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            sub_s3_r <= 1'b0;
        end else begin
            sub_s1_r <= SUB_CLK;
            sub_s2_r <= sub_s1_r;
            sub_s3_r <= sub_s2_r;
        end
    end

    wire sub_tick = sub_s2_r && !sub_s3_r;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            sub_cnt_r <= 2'b00;
            pre_cnt_r <= 8'h00;
        end else begin
            sub_cnt_r <= sub_tick ? sub_cnt_r + 2'b01 : sub_cnt_r;
            pre_cnt_r <= pre_cnt_r + 8'h01;
        end
    end

    wire [8:0] phi_span = (9'h002 << cks_w[2:0]) - 9'h001;
    wire [7:0] phi_mask = phi_span[7:0];
    wire phi_tick = (pre_cnt_r & phi_mask) == phi_mask;
    wire subw_tick = cks_w[1] ? (sub_tick && sub_cnt_r == 2'b11) :
                     cks_w[0] ? (sub_tick && sub_cnt_r[0]) : sub_tick;
    wire op_tick = cks_w[3] ? phi_tick : subw_tick;

    // ------------------------------------------------------------------
    // duty decode
    // ------------------------------------------------------------------
    // index of the last phase
    wire [1:0] last_w = duty_w[2] ? (duty_w[1] ? 2'b11 : 2'b10) :
                                    (duty_w[1] ? 2'b01 : 2'b00);
    wire mirror_w = (duty_w == lcdd_pkg::DUTY_STATIC_ALL) ||
                    (duty_w == lcdd_pkg::DUTY_HALF_ALL);

    genvar i;
    generate
        for (i = 0; i < lcdd_pkg::NUM_COM; i++) begin : g_com
            wire [1:0] ph_i = (duty_w == lcdd_pkg::DUTY_STATIC_ALL) ? 2'b00 :
                              (duty_w == lcdd_pkg::DUTY_HALF_ALL) ?
                              2'(i / 2) : 2'(i);
            wire used_i = mirror_w || (2'(i) <= last_w);
            assign drive_nxt.com_used[i] = used_i;
            assign drive_nxt.com_act[i] = used_i && (ph_i == phase_r);
        end
    endgenerate

    // ------------------------------------------------------------------
    // segment groups
    // ------------------------------------------------------------------
    logic [lcdd_pkg::NUM_GRP-1:0] grp_seg_w;
    logic [lcdd_pkg::NUM_SEG-1:0] pin_seg_w;

    genvar g;
    generate
        for (g = 0; g < lcdd_pkg::NUM_GRP; g++) begin : g_grp
            assign grp_seg_w[g] = sgs_w[3] ? (3'(g) >= sgs_w[2:0]) :
                                             (3'(g) < sgs_w[2:0]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // segment data
    // ------------------------------------------------------------------
    genvar s;
    generate
        for (s = 0; s < lcdd_pkg::NUM_SEG; s++) begin : g_seg
            localparam logic HI = 1'(s % 2);
            assign pin_seg_w[s] = grp_seg_w[s / lcdd_pkg::GRP_PINS];
            assign drive_nxt.seg_on[s] = display_data_show_w && pin_seg_w[s] &&
                                         ram_r[s / 2][{HI, phase_r}];
        end
    endgenerate

    assign drive_nxt.polarity = wave_b_w ? frame_r : half_r;

    // ------------------------------------------------------------------
    // common sequencer
    // ------------------------------------------------------------------
    always_comb begin
        case (state_r)
            lcdd_pkg::SEQ_IDLE: begin
                state_nxt = running_w ? lcdd_pkg::SEQ_RUN : lcdd_pkg::SEQ_IDLE;
            end
            lcdd_pkg::SEQ_RUN: begin
                state_nxt = running_w ? lcdd_pkg::SEQ_RUN : lcdd_pkg::SEQ_IDLE;
            end
            default: begin
                state_nxt = lcdd_pkg::SEQ_IDLE;
            end
        endcase
    end

    always_comb begin
        phase_nxt = phase_r;
        half_nxt = half_r;
        frame_nxt = frame_r;
        if (state_r != lcdd_pkg::SEQ_RUN) begin
            phase_nxt = 2'b00;
            half_nxt = 1'b0;
            frame_nxt = 1'b0;
        end else if (phase_r > last_w) begin
            phase_nxt = 2'b00;
            half_nxt = 1'b0;
        end else if (op_tick) begin
            half_nxt = !half_r;
            if (half_r) begin
                if (phase_r == last_w) begin
                    phase_nxt = 2'b00;
                    frame_nxt = !frame_r;
                end else begin
                    phase_nxt = phase_r + 2'b01;
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= lcdd_pkg::SEQ_IDLE;
            phase_r <= 2'b00;
            half_r <= 1'b0;
            frame_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            half_r <= half_nxt;
            frame_r <= frame_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // halted or port pins undriven
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            drive_r <= '0;
            seg_oe_r <= '0;
            port_sel_r <= '1;
            pwr_r <= 1'b0;
        end else begin
            drive_r <= (state_r == lcdd_pkg::SEQ_RUN) ? drive_nxt : '0;
            seg_oe_r <= running_w ? pin_seg_w : '0;
            port_sel_r <= ~pin_seg_w;
            pwr_r <= psw_w && running_w;
        end
    end

    assign DRIVE = drive_r;
    assign SEG_OE = seg_oe_r;
    assign PORT_SEL = port_sel_r;
    assign DRIVE_PWR_EN = pwr_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    property p_word_read;
        BUS_REQ.rd && BUS_REQ.word &&
        BUS_REQ.addr == lcdd_pkg::ADDR_RAM_BASE && !BUS_REQ.wr
        |=> BUS_RDATA == {ram_r[0], ram_r[1]};
    endproperty
    a_word_read: assert property (p_word_read)
        else $error("word read of display memory wrong");

    property p_rdata_idle;
        !BUS_REQ.rd |=> BUS_RDATA == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero after idle cycle");

    property p_halt;
        !act_w |=> !DRIVE_PWR_EN && SEG_OE == '0;
    endproperty
    a_halt: assert property (p_halt)
        else $error("driver not halted with activate clear");

    property p_standby;
        (STANDBY_MODE || MODULE_STBY) ##1 (STANDBY_MODE || MODULE_STBY)
        |=> DRIVE.com_act == '0 && !DRIVE_PWR_EN;
    endproperty
    a_standby: assert property (p_standby)
        else $error("drive active in standby");

    property p_blank;
        !display_data_show_w [*2] |-> DRIVE.seg_on == '0;
    endproperty
    a_blank: assert property (p_blank)
        else $error("segments lit while blank selected");

    property p_port_free;
        (SEG_OE & PORT_SEL) == '0 && (DRIVE.seg_on & PORT_SEL) == '0;
    endproperty
    a_port_free: assert property (p_port_free)
        else $error("port pin driven by lcd");

    property p_sgs_low;
        sgs_w == 4'h0 |=> SEG_OE == '0 && PORT_SEL == '1;
    endproperty
    a_sgs_low: assert property (p_sgs_low)
        else $error("select zero left segment pins");

    property p_sgs_high;
        sgs_w == 4'hF && running_w |=> SEG_OE == 32'hF0000000;
    endproperty
    a_sgs_high: assert property (p_sgs_high)
        else $error("select fifteen wrong groups");

    property p_static_all;
        duty_w == lcdd_pkg::DUTY_STATIC_ALL [*2]
        |-> DRIVE.com_act == 4'h0 || DRIVE.com_act == 4'hF;
    endproperty
    a_static_all: assert property (p_static_all)
        else $error("static commons differ");

    property p_half_all;
        duty_w == lcdd_pkg::DUTY_HALF_ALL [*2]
        |-> DRIVE.com_act[1] == DRIVE.com_act[0] &&
            DRIVE.com_act[3] == DRIVE.com_act[2];
    endproperty
    a_half_all: assert property (p_half_all)
        else $error("half duty copies wrong");

    property p_third;
        duty_w[2:1] == 2'b10 [*2] |-> !DRIVE.com_act[3];
    endproperty
    a_third: assert property (p_third)
        else $error("fourth common active in third duty");

    property p_phase_wrap;
        state_r == lcdd_pkg::SEQ_RUN && op_tick && half_r &&
        phase_r == last_w && $stable(pdc_r) |=> phase_r == 2'b00;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap)
        else $error("phase did not wrap at frame end");

    c_quarter: cover property (duty_w[2:1] == 2'b11 && phase_r == 2'b11);
    c_word_wr: cover property (BUS_REQ.wr && BUS_REQ.word);
    c_mixed: cover property (SEG_OE != '0 && PORT_SEL != '0);
    c_standby: cover property (act_w && STANDBY_MODE);

endmodule : lcdd_top

// ### core/lcdd_pkg.sv
// shared constants, types and register map of the segment lcd driver
package lcdd_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int NUM_SEG = 32;
    localparam int NUM_COM = 4;
    localparam int NUM_GRP = 8;
    localparam int GRP_PINS = 4;
    localparam int RAM_BYTES = 16;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_PORT_DUTY = 16'hFFA0;
    localparam logic [15:0] ADDR_MAIN_CTRL = 16'hFFA1;
    localparam logic [15:0] ADDR_CTRL2 = 16'hFFA2;
    localparam logic [15:0] ADDR_RAM_BASE = 16'hFFB0;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int PDC_DUTY_LSB = 5;
    localparam int PDC_SGS_LSB = 0;
    localparam int MC_PSW_BIT = 6;
    localparam int MC_ACT_BIT = 5;
    localparam int MC_DISPLAY_DATA_SHOW_BIT = 4;
    localparam int MC_CKS_LSB = 0;
    localparam int C2_WAVE_BIT = 7;

    // ------------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] PDC_RESET = 8'h00;
    localparam logic [7:0] MC_RESET = 8'h80;
    localparam logic [7:0] C2_RESET = 8'h00;
    localparam logic [7:0] PDC_WMASK = 8'hEF;
    localparam logic [7:0] MC_WMASK = 8'h7F;
    localparam logic [7:0] C2_WMASK = 8'hF0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DUTY_STATIC_C1 = 3'b000,
        DUTY_STATIC_ALL = 3'b001,
        DUTY_HALF_C12 = 3'b010,
        DUTY_HALF_ALL = 3'b011,
        DUTY_THIRD_A = 3'b100,
        DUTY_THIRD_B = 3'b101,
        DUTY_QUARTER_A = 3'b110,
        DUTY_QUARTER_B = 3'b111
    } lcdd_duty_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN = 2'b01
    } lcdd_seq_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
        logic word;
    } lcdd_bus_req_t;

    typedef struct packed {
        logic [NUM_COM-1:0] com_act;
        logic [NUM_COM-1:0] com_used;
        logic polarity;
        logic [NUM_SEG-1:0] seg_on;
    } lcdd_drive_t;

endpackage : lcdd_pkg

// ### tb/lcdd_panel.sv
// passive glass model: latches the lit pattern seen under each common
`timescale 1ns/1ps
module lcdd_panel (
    input wire logic clk,
    input wire lcdd_pkg::lcdd_drive_t drive,
    input wire logic [31:0] seg_oe,
    input wire logic clr,
    output logic [3:0][31:0] lit,
    output logic [3:0] seen
);
    // undriven segment pins float and show nothing
    always_ff @(posedge clk) begin
        seen <= clr ? 4'h0 : (seen | drive.com_act);
        for (int c = 0; c < 4; c++) begin
            if (drive.com_act[c]) begin
                lit[c] <= drive.seg_on & seg_oe;
            end
        end
    end
endmodule : lcdd_panel

// ### tb/tb.sv
// self-checking testbench of the segment lcd driver
`timescale 1ns/1ps
module tb;
    logic CLK;
    logic RST_B;
    lcdd_pkg::lcdd_bus_req_t BUS_REQ;
    logic [15:0] BUS_RDATA;
    logic SUB_CLK;
    logic STANDBY_MODE;
    logic MODULE_STBY;
    lcdd_pkg::lcdd_drive_t DRIVE;
    logic [31:0] SEG_OE;
    logic [31:0] PORT_SEL;
    logic DRIVE_PWR_EN;
    logic clr;
    logic [3:0][31:0] lit;
    logic [3:0] seen;
    logic [7:0] mem [16];
    int n_fail;
    int compares;
    lcdd_top u_lcdd_top (.CLK(CLK), .RST_B(RST_B), .BUS_REQ(BUS_REQ),
        .BUS_RDATA(BUS_RDATA), .SUB_CLK(SUB_CLK),
        .STANDBY_MODE(STANDBY_MODE), .MODULE_STBY(MODULE_STBY),
        .DRIVE(DRIVE), .SEG_OE(SEG_OE), .PORT_SEL(PORT_SEL),
        .DRIVE_PWR_EN(DRIVE_PWR_EN));
    lcdd_panel u_lcdd_panel (.clk(CLK), .drive(DRIVE), .seg_oe(SEG_OE),
        .clr(clr), .lit(lit), .seen(seen));
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    initial begin
        SUB_CLK = 1'b0;
        forever #40 SUB_CLK = ~SUB_CLK;
    end
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic bus(input logic [15:0] a, input logic [15:0] d,
                       input logic w, input logic wd);
        @(posedge CLK);
        BUS_REQ <= {a, d, w, ~w, wd};
        @(posedge CLK);
        BUS_REQ.wr <= 1'b0;
        BUS_REQ.rd <= 1'b0;
        #1;
    endtask : bus
    task automatic rc(input string nm, input logic [15:0] a,
                      input logic wd, input logic [15:0] e);
        bus(a, 16'h0000, 1'b0, wd);
        chk(nm, BUS_RDATA, e);
    endtask : rc
    task automatic idle(input int n);
        repeat (n) @(posedge CLK);
    endtask : idle
    function automatic logic [31:0] colv(input int c, input logic [31:0] m);
        logic [31:0] e;
        for (int s = 0; s < 32; s++) e[s] = mem[s/2][(s%2)*4+c] & m[s];
        return e;
    endfunction : colv
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk("port_sel", PORT_SEL, 32'hFFFFFFFF);
        rc("main", 16'hFFA1, 1'b0, 16'h0080);
        rc("unmapped", 16'hFFA5, 1'b0, 16'h0000);
        for (int i = 0; i < 16; i++) mem[i] = 8'(i * 29 + 7);
        for (int i = 0; i < 8; i++) begin
            bus(16'(16'hFFB0 + 2 * i), {mem[2*i], mem[2*i+1]}, 1'b1, 1'b1);
        end
        mem[5] = 8'hC3;
        bus(16'hFFB5, 16'h00C3, 1'b1, 1'b0);
        rc("word", 16'hFFB4, 1'b1, {mem[4], mem[5]});
        rc("byte", 16'hFFB5, 1'b0, {8'h00, mem[5]});
        rc("word0", 16'hFFB0, 1'b1, {mem[0], mem[1]});
        bus(16'hFFA0, 16'h00FF, 1'b1, 1'b0);
        rc("pdc", 16'hFFA0, 1'b0, 16'h00EF);
    endtask : t_reset
    task automatic t_groups();
        logic [31:0] e;
        for (int v = 0; v < 16; v++) begin
            bus(16'hFFA0, 16'(8'hC0 | v), 1'b1, 1'b0);
            for (int g = 0; g < 8; g++) begin
                e[4*g+:4] = (v[3] ? g >= v[2:0] : g < v[2:0]) ? 4'h0 : 4'hF;
            end
            idle(3);
            chk("port_sel", PORT_SEL, e);
            chk("seg_oe", SEG_OE, 32'h0);
        end
    endtask : t_groups
    task automatic t_run();
        bus(16'hFFA0, 16'h00C9, 1'b1, 1'b0);
        bus(16'hFFA1, 16'h0078, 1'b1, 1'b0);
        idle(60);
        chk("pwr", DRIVE_PWR_EN, 1'b1);
        chk("seg_oe", SEG_OE, 32'hFFFFFFF0);
        for (int c = 0; c < 4; c++) begin
            chk("lit", lit[c], colv(c, 32'hFFFFFFF0));
        end
        bus(16'hFFA0, 16'h00CF, 1'b1, 1'b0);
        idle(3);
        chk("seg_oe", SEG_OE, 32'hF0000000);
        @(posedge CLK);
        STANDBY_MODE <= 1'b1;
        idle(4);
        chk("pwr", DRIVE_PWR_EN, 1'b0);
        @(posedge CLK);
        STANDBY_MODE <= 1'b0;
        MODULE_STBY <= 1'b1;
        idle(4);
        chk("seg_oe", SEG_OE, 32'h0);
        @(posedge CLK);
        MODULE_STBY <= 1'b0;
    endtask : t_run
    task automatic t_duty();
        for (int d = 0; d < 8; d++) begin
            bus(16'hFFA0, 16'(d * 32 + 8), 1'b1, 1'b0);
            @(posedge CLK);
            clr <= 1'b1;
            idle(4);
            clr <= 1'b0;
            idle(40);
            chk("coms", seen, 4'(32'hFF77F3F1 >> (4 * d)));
            chk("used", DRIVE.com_used, 4'(32'hFF77F3F1 >> (4 * d)));
            if (d == 1) chk("c4", lit[3], colv(0, '1));
            if (d == 3) chk("c4", lit[3], colv(1, '1));
            if (d == 4) chk("c3", lit[2], colv(2, '1));
        end
    endtask : t_duty
    task automatic t_blank();
        bus(16'hFFA1, 16'h0070, 1'b1, 1'b0);
        @(posedge CLK);
        clr <= 1'b1;
        idle(2);
        clr <= 1'b0;
        idle(300);
        chk("sub", seen, 4'hF);
        bus(16'hFFA1, 16'h0068, 1'b1, 1'b0);
        idle(40);
        chk("blank", lit[0], 32'h0);
        bus(16'hFFA1, 16'h0058, 1'b1, 1'b0);
        idle(4);
        chk("act", {DRIVE.com_act, SEG_OE[0], DRIVE_PWR_EN}, 6'h0);
        rc("kept", 16'hFFA1, 1'b0, 16'h00D8);
    endtask : t_blank
    task automatic flips(input string nm, input logic [15:0] mc,
                         input logic [15:0] c2, input logic [31:0] e);
        logic [31:0] n;
        logic p;
        bus(16'hFFA1, mc, 1'b1, 1'b0);
        bus(16'hFFA2, c2, 1'b1, 1'b0);
        idle(40);
        n = '0;
        p = DRIVE.polarity;
        repeat (64) begin
            @(posedge CLK);
            if (DRIVE.polarity !== p) n = n + 32'h1;
            p = DRIVE.polarity;
        end
        chk(nm, n, e);
    endtask : flips
    task automatic t_wave();
        flips("wave_a", 16'h0078, 16'h0000, 32'h20);
        flips("wave_b", 16'h0078, 16'h008F, 32'h4);
        rc("ctrl2", 16'hFFA2, 1'b0, 16'h0080);
        flips("rate_sub", 16'h0070, 16'h0000, 32'h4);
        flips("rate_sub2", 16'h0071, 16'h0000, 32'h2);
        flips("rate_sub4", 16'h0072, 16'h0000, 32'h1);
        flips("rate_phi8", 16'h007A, 16'h0000, 32'h8);
    endtask : t_wave
    task automatic test_done();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        RST_B = 1'b0;
        BUS_REQ = '0;
        STANDBY_MODE = 1'b0;
        MODULE_STBY = 1'b0;
        clr = 1'b0;
        n_fail = 0;
        compares = 0;
        idle(12);
        RST_B <= 1'b1;
        t_reset();
        t_groups();
        t_run();
        t_duty();
        t_wave();
        t_blank();
        test_done();
    end
    initial begin
        idle(20000);
        n_fail++;
        test_done();
    end
endmodule : tb
